/* File: rtl/gsc_pkg.sv */
// Package for the gated sixteen-bit counter: register map, fields, reset values
package gsc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] GSC_OFS_CTRL   = 8'h00;
    localparam logic [7:0] GSC_OFS_GATE   = 8'h04;
    localparam logic [7:0] GSC_OFS_CNT_LO = 8'h08;
    localparam logic [7:0] GSC_OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] GSC_OFS_FLAG   = 8'h10;
    localparam logic [7:0] GSC_OFS_IEN    = 8'h14;
    localparam logic [7:0] GSC_OFS_CORE   = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GSC_FLAG_OVF  = 0;
    localparam int GSC_FLAG_GATE = 7;
    localparam int GSC_CORE_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int GSC_CORE_GIE  = 7;
    localparam int GSC_GATE_VAL  = 2;

    // ------------------------------------------------------------
    // Encodings, counts and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] GSC_CS_INSTR = 2'h0;
    localparam logic [1:0] GSC_CS_SYS   = 2'h1;
    localparam logic [1:0] GSC_CS_EXT   = 2'h2;
    localparam logic [1:0] GSC_CS_LFOSC = 2'h3;
    localparam logic [1:0] GSC_GS_PIN   = 2'h0;
    localparam logic [1:0] GSC_GS_WRAP  = 2'h1;
    localparam logic [1:0] GSC_GS_CMP1  = 2'h2;
    localparam logic [1:0] GSC_GS_CMP2  = 2'h3;
    localparam logic [1:0] GSC_INSTR_DIV_LAST = 2'h3;
    localparam logic [7:0] GSC_TMR8_MAX  = 8'hFF;
    localparam logic [15:0] GSC_CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] GSC_CNT_RST  = 16'h0000;

    // ------------------------------------------------------------
    // Control carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] clk_src;
        logic [1:0] prescale;
        logic       pad3;
        logic       sync_bypass;
        logic       pad1;
        logic       counter_on;
    } gsc_ctrl_t;

    typedef struct packed {
        logic       gate_en;
        logic       gate_pol;
        logic       toggle_en;
        logic       single_en;
        logic       arm;
        logic       level;
        logic [1:0] gate_src;
    } gsc_gate_t;

    localparam gsc_ctrl_t GSC_CTRL_RST = 8'h00;
    localparam gsc_gate_t GSC_GATE_RST = 8'h00;
endpackage : gsc_pkg

/* File: rtl/gsc_counter.sv */
// Gated sixteen-bit counter with APB register access
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module gsc_counter
    import gsc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        external_count_input,
    input  wire logic        low_freq_internal_osc,
    input  wire logic        gate_pin,
    input  wire logic [7:0]  eight_bit_timer_count,
    input  wire logic        comparator_one_output,
    input  wire logic        comparator_two_output,
    input  wire logic        sleep_mode,
    output logic             irq,
    output logic             wake
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    gsc_ctrl_t   ctrl;
    gsc_gate_t   gate;
    logic [15:0] count;
    logic        overflow_flag;
    logic        gate_event_flag;
    logic        overflow_irq_enable;
    logic        gate_event_irq_enable;
    logic        peripheral_irq_enable;
    logic        global_irq_enable;

    logic        wr_en;
    logic        wr_lo;
    logic        wr_hi;
    logic        mapped;

    function automatic logic is_mapped(input logic [7:0] a);
        return a == GSC_OFS_CTRL || a == GSC_OFS_GATE || a == GSC_OFS_CNT_LO ||
               a == GSC_OFS_CNT_HI || a == GSC_OFS_FLAG || a == GSC_OFS_IEN ||
               a == GSC_OFS_CORE;
    endfunction : is_mapped

    assign mapped = is_mapped(paddr);
    assign wr_en  = psel && penable && pready && pwrite && mapped;
    assign wr_lo  = wr_en && paddr == GSC_OFS_CNT_LO;
    assign wr_hi  = wr_en && paddr == GSC_OFS_CNT_HI;

    // ------------------------------------------------------------
    // APB slave: no wait state, answer in access phase
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    GSC_OFS_CTRL:   prdata[7:0] <= ctrl & 8'hF5;
                    GSC_OFS_GATE:   prdata[7:0] <= gate;
                    GSC_OFS_CNT_LO: prdata[7:0] <= count[7:0];
                    GSC_OFS_CNT_HI: prdata[7:0] <= count[15:8];
                    GSC_OFS_FLAG: begin
                        prdata[GSC_FLAG_OVF]  <= overflow_flag;
                        prdata[GSC_FLAG_GATE] <= gate_event_flag;
                    end
                    GSC_OFS_IEN: begin
                        prdata[GSC_FLAG_OVF]  <= overflow_irq_enable;
                        prdata[GSC_FLAG_GATE] <= gate_event_irq_enable;
                    end
                    GSC_OFS_CORE: begin
                        prdata[GSC_CORE_PERIPHERAL_IRQ_ENABLE] <= peripheral_irq_enable;
                        prdata[GSC_CORE_GIE]  <= global_irq_enable;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl                  <= GSC_CTRL_RST;
            overflow_irq_enable   <= 1'b0;
            gate_event_irq_enable <= 1'b0;
            peripheral_irq_enable <= 1'b0;
            global_irq_enable     <= 1'b0;
        end else if (wr_en) begin
            if (paddr == GSC_OFS_CTRL) ctrl <= pwdata[7:0] & 8'hF5;
            if (paddr == GSC_OFS_IEN) begin
                overflow_irq_enable   <= pwdata[GSC_FLAG_OVF];
                gate_event_irq_enable <= pwdata[GSC_FLAG_GATE];
            end
            if (paddr == GSC_OFS_CORE) begin
                peripheral_irq_enable <= pwdata[GSC_CORE_PERIPHERAL_IRQ_ENABLE];
                global_irq_enable     <= pwdata[GSC_CORE_GIE];
            end
        end
    end

    // ------------------------------------------------------------
    // Count clock sources
    // ------------------------------------------------------------
    logic [1:0] instr_div;
    logic       ext_s1;
    logic       ext_s2;
    logic       ext_prev;
    logic       lf_prev;
    logic       ext_lvl;
    logic       src_edge;
    logic       async_ext;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) instr_div <= 2'h0;
        else          instr_div <= instr_div + 2'h1;
    end

    // Edge trackers run in sleep too so no edge is invented on wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1   <= 1'b0;
            ext_s2   <= 1'b0;
            ext_prev <= 1'b0;
            lf_prev  <= 1'b0;
        end else begin
            ext_s1   <= external_count_input;
            ext_s2   <= ext_s1;
            ext_prev <= ext_lvl;
            lf_prev  <= low_freq_internal_osc;
        end
    end

    // Path switch can drop or add one edge when the bypass flips
    assign ext_lvl   = ctrl.sync_bypass ? external_count_input : ext_s2;
    assign async_ext = ctrl.sync_bypass && ctrl.clk_src == GSC_CS_EXT;

    always_comb begin
        unique case (ctrl.clk_src)
            GSC_CS_INSTR: src_edge = instr_div == GSC_INSTR_DIV_LAST;
            GSC_CS_SYS:   src_edge = 1'b1;
            GSC_CS_EXT:   src_edge = ext_lvl && !ext_prev;
            GSC_CS_LFOSC: src_edge = low_freq_internal_osc && !lf_prev;
        endcase
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic [2:0] presc;
    logic [2:0] presc_mask;
    logic       tick;

    assign presc_mask = 3'((4'h1 << ctrl.prescale) - 4'h1);
    assign tick       = src_edge && (presc & presc_mask) == presc_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)             presc <= 3'h0;
        else if (wr_lo || wr_hi)  presc <= 3'h0;
        else if (ctrl.counter_on && src_edge) presc <= presc + 3'h1;
    end

    // ------------------------------------------------------------
    // Gate path
    // ------------------------------------------------------------
    logic [7:0] tmr8_prev;
    logic       wrap_pulse;
    logic       gate_raw;
    logic       gate_act;
    logic       gate_act_prev;
    logic       toggle_q;
    logic       gate_tog;
    logic       gate_tog_prev;
    logic       gate_value;
    logic       gate_rise;
    logic       gate_fall;
    logic       sp_window;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr8_prev  <= 8'h00;
            wrap_pulse <= 1'b0;
        end else begin
            tmr8_prev  <= eight_bit_timer_count;
            wrap_pulse <= tmr8_prev == GSC_TMR8_MAX && eight_bit_timer_count == 8'h00;
        end
    end

    always_comb begin
        unique case (gate.gate_src)
            GSC_GS_PIN:  gate_raw = gate_pin;
            GSC_GS_WRAP: gate_raw = wrap_pulse;
            GSC_GS_CMP1: gate_raw = comparator_one_output;
            GSC_GS_CMP2: gate_raw = comparator_two_output;
        endcase
    end

    // Active when the level equals the polarity bit
    assign gate_act  = gate_raw == gate.gate_pol;
    assign gate_tog  = gate.toggle_en ? toggle_q : gate_act;
    assign gate_rise = gate_tog && !gate_tog_prev;
    assign gate_fall = !gate_tog && gate_tog_prev;
    assign gate_value = gate.single_en ? sp_window : gate_tog;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_act_prev <= 1'b0;
            gate_tog_prev <= 1'b0;
            toggle_q      <= 1'b0;
        end else begin
            gate_act_prev <= gate_act;
            gate_tog_prev <= gate_tog;
            if (!gate.toggle_en || !ctrl.counter_on)
                toggle_q <= 1'b0;
            else if (gate_act && !gate_act_prev)
                toggle_q <= !toggle_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sp_window <= 1'b0;
        else if (!gate.single_en || gate_fall) sp_window <= 1'b0;
        else if (gate.arm && gate_rise) sp_window <= 1'b1;
    end

    // Gate control register; arm is cleared by hardware on trailing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate <= GSC_GATE_RST;
        end else begin
            if (wr_en && paddr == GSC_OFS_GATE) begin
                gate.gate_en   <= pwdata[7];
                gate.gate_pol  <= pwdata[6];
                gate.toggle_en <= pwdata[5];
                gate.single_en <= pwdata[4];
                gate.arm       <= pwdata[3] && pwdata[4];
                gate.gate_src  <= pwdata[1:0];
            end
            if (gate.single_en && sp_window && gate_fall)
                gate.arm <= 1'b0;
            gate.level <= gate_value;
        end
    end

    // ------------------------------------------------------------
    // Counter and flags
    // ------------------------------------------------------------
    logic count_en;
    logic inc;
    logic ovf_set;
    logic gev_set;
    logic ovf_req;

    assign count_en = ctrl.counter_on && (!gate.gate_en || gate_value);
    assign inc      = count_en && tick && (!sleep_mode || async_ext);
    assign ovf_set  = inc && !wr_lo && !wr_hi && count == GSC_CNT_MAX;
    assign gev_set  = gate.level && !gate_value;
    assign ovf_req  = overflow_flag && overflow_irq_enable && ctrl.counter_on &&
                      peripheral_irq_enable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)   count <= GSC_CNT_RST;
        else if (wr_lo) count[7:0] <= pwdata[7:0];
        else if (wr_hi) count[15:8] <= pwdata[7:0];
        else if (inc)   count <= count + 16'h0001;
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag   <= 1'b0;
            gate_event_flag <= 1'b0;
        end else begin
            if (ovf_set)
                overflow_flag <= 1'b1;
            else if (wr_en && paddr == GSC_OFS_FLAG)
                overflow_flag <= pwdata[GSC_FLAG_OVF];
            if (gev_set)
                gate_event_flag <= 1'b1;
            else if (wr_en && paddr == GSC_OFS_FLAG)
                gate_event_flag <= pwdata[GSC_FLAG_GATE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= global_irq_enable && (ovf_req ||
                    (gate_event_flag && gate_event_irq_enable && peripheral_irq_enable));
            wake <= sleep_mode && ovf_req;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ovf_sets;
        @(posedge pclk) disable iff (!presetn) ovf_set |=> overflow_flag && count == 16'h0000;
    endproperty
    a_ovf_sets: assert property (p_ovf_sets) else $error("overflow not flagged");

    property p_hold_off;
        @(posedge pclk) disable iff (!presetn)
            !ctrl.counter_on && !wr_lo && !wr_hi |=> count == $past(count);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("count moved while off");

    property p_gate_hold;
        @(posedge pclk) disable iff (!presetn)
            gate.gate_en && !gate_value && !wr_lo && !wr_hi |=> $stable(count);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("count moved gated");

    property p_irq_gie;
        @(posedge pclk) disable iff (!presetn) !global_irq_enable |=> !irq;
    endproperty
    a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");

    property p_ovf_irq;
        @(posedge pclk) disable iff (!presetn)
            ovf_req && global_irq_enable |=> irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

    property p_gev;
        @(posedge pclk) disable iff (!presetn)
            $fell(gate.level) |-> gate_event_flag;
    endproperty
    a_gev: assert property (p_gev) else $error("gate event flag missing");

    property p_toggle_clr;
        @(posedge pclk) disable iff (!presetn)
            !gate.toggle_en || !ctrl.counter_on |=> !toggle_q;
    endproperty
    a_toggle_clr: assert property (p_toggle_clr) else $error("toggle not cleared");

    property p_arm_clr;
        @(posedge pclk) disable iff (!presetn)
            gate.single_en && sp_window && gate_fall && !wr_en |=> !gate.arm && !sp_window;
    endproperty
    a_arm_clr: assert property (p_arm_clr) else $error("arm not cleared");

    property p_presc_clr;
        @(posedge pclk) disable iff (!presetn) wr_lo || wr_hi |=> presc == 3'h0;
    endproperty
    a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared");

    property p_sleep_sync;
        @(posedge pclk) disable iff (!presetn)
            sleep_mode && !async_ext && !wr_lo && !wr_hi |=> $stable(count);
    endproperty
    a_sleep_sync: assert property (p_sleep_sync) else $error("count moved in sleep");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
            tmr8_prev == 8'hFF && eight_bit_timer_count == 8'h00 |=> wrap_pulse;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap pulse missing");

    c_overflow: cover property (@(posedge pclk) disable iff (!presetn) ovf_set);
    c_single:   cover property (@(posedge pclk) disable iff (!presetn) $fell(gate.arm));
    c_wake:     cover property (@(posedge pclk) disable iff (!presetn) wake);
    c_toggle:   cover property (@(posedge pclk) disable iff (!presetn) $rose(toggle_q));
endmodule : gsc_counter

/* File: bench/gsc_partner.sv */
// Far-side model: external count clock, gate sources and eight-bit timer
`timescale 1ns/1ps
module gsc_partner (
    input  wire logic       pclk,
    output logic            ext_clk,
    output logic            lf_osc,
    output logic            gate_pin,
    output logic            cmp_one,
    output logic            cmp_two,
    output logic [7:0]      tmr8
);
    logic [2:0] lf_cnt = 3'h0;

    initial begin
        ext_clk  = 1'b0;
        gate_pin = 1'b0;
        cmp_one  = 1'b0;
        cmp_two  = 1'b0;
        tmr8     = 8'hFE;
    end

    // Low-frequency oscillator runs free, one rising edge per 8 cycles
    always @(posedge pclk) lf_cnt <= lf_cnt + 3'h1;
    assign lf_osc = lf_cnt[2];

    // Count clock stands low between bursts
    task pulses(input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_clk <= 1'b1;
            repeat (3) @(posedge pclk);
            ext_clk <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : pulses

    task drive(input logic [1:0] s, input logic l);
        @(posedge pclk);
        case (s)
            2'h0: gate_pin <= l;
            2'h2: cmp_one <= l;
            2'h3: cmp_two <= l;
            default: tmr8 <= l ? 8'hFF : 8'hFE;
        endcase
        if (s == 2'h1 && l) begin
            @(posedge pclk);
            tmr8 <= 8'h00;
        end
    endtask : drive
endmodule : gsc_partner

/* File: bench/test_gated_sixteen_bit_counter.sv */
// Self-checking bench for the gated sixteen-bit counter
`timescale 1ns/1ps
module test_gated_sixteen_bit_counter;
    import gsc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        sleep_mode, irq, wake, ext_clk, lf_osc, gate_pin, cmp_one, cmp_two;
    logic [7:0]  paddr, tmr8;
    logic [31:0] pwdata, prdata, rd;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;

    gsc_counter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .external_count_input(ext_clk), .low_freq_internal_osc(lf_osc),
        .gate_pin(gate_pin), .eight_bit_timer_count(tmr8), .comparator_one_output(cmp_one),
        .comparator_two_output(cmp_two), .sleep_mode(sleep_mode), .irq(irq), .wake(wake));
    gsc_partner part_u (.pclk(pclk), .ext_clk(ext_clk), .lf_osc(lf_osc),
        .gate_pin(gate_pin), .cmp_one(cmp_one), .cmp_two(cmp_two), .tmr8(tmr8));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] near(input logic [31:0] v, input int e);
        return {31'h0, (int'(v) >= e - 2) && (int'(v) <= e + 2)};
    endfunction : near

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Clear count while stopped, run for n cycles, stop, read low byte
    task run(input logic [31:0] c, input logic [31:0] g, input int n);
        apb(1'b1, GSC_OFS_CTRL, c & 32'hFE);
        apb(1'b1, GSC_OFS_CNT_LO, 32'h0);
        apb(1'b1, GSC_OFS_CNT_HI, 32'h0);
        apb(1'b1, GSC_OFS_GATE, g);
        apb(1'b1, GSC_OFS_CTRL, c);
        repeat (n) @(posedge pclk);
        apb(1'b1, GSC_OFS_CTRL, c & 32'hFE);
        apb(1'b0, GSC_OFS_CNT_LO, 32'h0);
    endtask : run

    task pin(input int hi, input int lo);
        part_u.drive(2'h0, 1'b1);
        repeat (hi) @(posedge pclk);
        part_u.drive(2'h0, 1'b0);
        repeat (lo) @(posedge pclk);
    endtask : pin

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset();
        for (int a = 0; a <= 'h1C; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check("reset_value", rd, a == GSC_OFS_GATE ? 32'h4 : 32'h0);
            check("slverr", {31'h0, err}, {31'h0, a == 'h1C});
        end
        $display("test reset done");
    endtask : t_reset

    task t_rates();
        int div;
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 4; p++) begin
                div = (s == 0 ? 4 : s == 3 ? 8 : 1) << p;
                if (s != 2) run(32'(s * 64 + p * 16 + 1), 32'h0, 128);
                if (s != 2) check("rate", near(rd, 130 / div), 32'h1);
            end
        end
        run(32'h40, 32'h0, 40);
        check("off", rd, 32'h0);
        $display("test rates done");
    endtask : t_rates

    task t_ext();
        apb(1'b1, GSC_OFS_CNT_LO, 32'hFE);
        apb(1'b1, GSC_OFS_CNT_HI, 32'hFF);
        apb(1'b1, GSC_OFS_IEN, 32'h1);
        apb(1'b1, GSC_OFS_CORE, 32'h40);
        apb(1'b1, GSC_OFS_CTRL, 32'h81);
        part_u.pulses(3);
        apb(1'b0, GSC_OFS_CNT_LO, 32'h0);
        check("sync_count", rd, 32'h1);
        apb(1'b0, GSC_OFS_FLAG, 32'h0);
        check("ovf_flag", rd, 32'h1);
        check("irq_no_global", {31'h0, irq}, 32'h0);
        apb(1'b1, GSC_OFS_CORE, 32'hC0);
        repeat (2) @(posedge pclk);
        check("irq_all_set", {31'h0, irq}, 32'h1);
        apb(1'b1, GSC_OFS_FLAG, 32'h0);
        sleep_mode <= 1'b1;
        part_u.pulses(2);
        apb(1'b0, GSC_OFS_CNT_LO, 32'h0);
        check("sleep_sync", rd, 32'h1);
        apb(1'b1, GSC_OFS_CTRL, 32'h85);
        part_u.pulses(4);
        apb(1'b0, GSC_OFS_CNT_LO, 32'h0);
        check("sleep_bypass", rd, 32'h5);
        apb(1'b1, GSC_OFS_CTRL, 32'h84);
        apb(1'b1, GSC_OFS_CNT_LO, 32'hFF);
        apb(1'b1, GSC_OFS_CNT_HI, 32'hFF);
        apb(1'b1, GSC_OFS_CORE, 32'h40);
        apb(1'b1, GSC_OFS_CTRL, 32'h85);
        part_u.pulses(1);
        check("wake", {31'h0, wake}, 32'h1);
        check("irq_asleep", {31'h0, irq}, 32'h0);
        sleep_mode <= 1'b0;
        apb(1'b1, GSC_OFS_CTRL, 32'h0);
        apb(1'b1, GSC_OFS_FLAG, 32'h0);
        $display("test external done");
    endtask : t_ext

    task t_gate();
        apb(1'b1, GSC_OFS_IEN, 32'h80);
        apb(1'b1, GSC_OFS_CORE, 32'hC0);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, GSC_OFS_GATE, 32'(64 + s));
            apb(1'b1, GSC_OFS_FLAG, 32'h0);
            part_u.drive(2'(s), 1'b1);
            apb(1'b0, GSC_OFS_GATE, 32'h0);
            if (s != 1) check("level_high", rd, 32'(68 + s));
            part_u.drive(2'(s), 1'b0);
            apb(1'b0, GSC_OFS_GATE, 32'h0);
            check("level_low", rd, 32'(64 + s));
            apb(1'b0, GSC_OFS_FLAG, 32'h0);
            check("gate_event", rd, 32'h80);
            check("gate_irq", {31'h0, irq}, 32'h1);
        end
        apb(1'b1, GSC_OFS_FLAG, 32'h0);
        run(32'h41, 32'hC0, 40);
        check("gate_hold", rd, 32'h0);
        run(32'h41, 32'h80, 40);
        check("gate_low_active", near(rd, 42), 32'h1);
        $display("test gate done");
    endtask : t_gate

    task t_pulse();
        run(32'h40, 32'hD0, 1);
        apb(1'b1, GSC_OFS_GATE, 32'hD8);
        apb(1'b1, GSC_OFS_CTRL, 32'h41);
        pin(20, 10);
        pin(20, 10);
        apb(1'b0, GSC_OFS_GATE, 32'h0);
        check("arm_done", rd, 32'hD0);
        apb(1'b0, GSC_OFS_CNT_LO, 32'h0);
        check("single_pulse", near(rd, 21), 32'h1);
        run(32'h40, 32'hF0, 1);
        apb(1'b1, GSC_OFS_GATE, 32'hF8);
        apb(1'b1, GSC_OFS_CTRL, 32'h41);
        pin(10, 10);
        pin(10, 10);
        pin(10, 10);
        apb(1'b0, GSC_OFS_CNT_LO, 32'h0);
        check("full_period", near(rd, 22), 32'h1);
        apb(1'b1, GSC_OFS_GATE, 32'hC0);
        apb(1'b1, GSC_OFS_CTRL, 32'h0);
        $display("test single pulse done");
    endtask : t_pulse

    task finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        sleep_mode = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rates();
        t_ext();
        t_gate();
        t_pulse();
        finish_test();
    end
endmodule : test_gated_sixteen_bit_counter
